/* File: rtl/ddrdr_top.sv */
// ddr dual-line read engine of the serial flash
`timescale 1ns/1ps
`default_nettype none
module ddrdr_top
    import ddrdr_pkg::*;
#(
    parameter logic [31:0] ARRAY_TOP = ARRAY_TOP_DEF
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // serial pins
    input  wire logic        sck,
    input  wire logic        sel_n,
    input  wire logic        hold_n,
    input  wire logic        serial_line_zero_in,
    input  wire logic        serial_line_one_in,
    output logic             serial_line_zero_out,
    output logic             serial_line_one_out,
    output logic             serial_line_zero_oe,
    output logic             serial_line_one_oe,
    // configuration
    input  wire logic        four_byte_address_mode,
    input  wire logic        enhanced_latency_table,
    input  wire logic [1:0]  latency_code_field,
    input  wire logic        learning_pattern_en,
    input  wire logic [7:0]  learning_pattern,
    // array read port
    output logic [31:0]      array_addr,
    input  wire logic [7:0]  array_data,
    // status
    output logic             continuous_mode,
    output logic             busy
);
    ddrdr_edge_if ev ();
    ddrdr_sync u_sync
    (
        .clk      (clk),
        .arst_n   (arst_n),
        .sck      (sck),
        .sel_n    (sel_n),
        .line0_in (serial_line_zero_in),
        .line1_in (serial_line_one_in),
        .ev       (ev)
    );

    ddrdr_state_e state_ff, nxt_state;
    logic [31:0] shift_ff;
    logic [5:0]  bit_cnt_ff;
    logic [4:0]  clk_cnt_ff;
    logic [4:0]  sel_clks_ff;
    logic        busy_ff;
    logic        cont_ff;
    logic        cont_drop_ff;
    logic        wide_ff;
    logic [31:0] addr_ff;
    logic [7:0]  dbyte_ff;
    logic [1:0]  out_ff;
    logic        oe_ff;
    logic [4:0]  lat_ff;

    // a whole clock is a rise; a half clock is any edge
    wire        edge_any   = ev.rise | ev.fall;
    // the fall closing the last instruction clock carries no address bits
    wire        dual_edge  = ev.rise | (ev.fall & (bit_cnt_ff != 6'h00));
    wire        abort      = ev.sel_end;
    wire [5:0]  addr_bits  = wide_ff ? 6'h20 : 6'h18;
    wire        mode_cmpl  = shift_ff[5:2] == ~{shift_ff[1:0], ev.lines};
    wire [31:0] addr_in    = wide_ff ? shift_ff : {8'h00, shift_ff[23:0]};
    wire [31:0] addr_nxt   = (addr_ff >= ARRAY_TOP) ? 32'h0000_0000 : addr_ff + 32'h1;
    // data phase: edge 0 of a byte steps the address, edge 3 loads the next byte
    wire        byte_step  = (state_ff == DDRDR_DATA) & edge_any & (bit_cnt_ff[1:0] == 2'h0);
    wire        byte_load  = (state_ff == DDRDR_DATA) & edge_any & (bit_cnt_ff[1:0] == 2'h3);
    wire [4:0]  pre_start  = (lat_ff > PREAMBLE_CLKS) ? lat_ff - PREAMBLE_CLKS : 5'h00;
    wire        pre_phase  = learning_pattern_en & (clk_cnt_ff >= pre_start);
    wire [2:0]  pre_idx    = 3'(((clk_cnt_ff - pre_start) << 1) + {4'h0, ev.rise});

    function automatic logic opc_valid(input logic [6:0] hi, input logic lo);
        logic [7:0] b;
        b = {hi, lo};
        opc_valid = (b == OPC_DDR_DUAL) | (b == OPC_DDR_DUAL_WIDE);
    endfunction

    // hold_n is deliberately not used: hold has no effect on this command
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            DDRDR_IDLE:  if (ev.sel_start) nxt_state = cont_ff ? DDRDR_ADDR : DDRDR_INSTR;
            DDRDR_INSTR: if (ev.rise && bit_cnt_ff == 6'(INSTR_BITS - 5'h1))
                             nxt_state = (opc_valid(shift_ff[6:0], ev.lines[0])) ? DDRDR_ADDR : DDRDR_SKIP;
            DDRDR_ADDR:  if (dual_edge && bit_cnt_ff == addr_bits - 6'h2)
                             nxt_state = enhanced_latency_table ? DDRDR_MODE : DDRDR_LAT;
            DDRDR_MODE:  if (dual_edge && bit_cnt_ff == 6'h6) nxt_state = DDRDR_LAT;
            DDRDR_LAT:   if (ev.fall && clk_cnt_ff == lat_ff) nxt_state = DDRDR_DATA;
            DDRDR_DATA:  nxt_state = DDRDR_DATA;
            DDRDR_SKIP:  nxt_state = DDRDR_SKIP;
            default:     nxt_state = DDRDR_IDLE;
        endcase
        if (abort)
            nxt_state = DDRDR_IDLE;
    end

    // instruction is single line on rising edges; address/mode two bits per edge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff   <= DDRDR_IDLE;
            shift_ff   <= 32'h0;
            bit_cnt_ff <= 6'h0;
            clk_cnt_ff <= 5'h0;
            wide_ff    <= 1'b0;
            lat_ff     <= 5'h0;
            busy_ff    <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            busy_ff  <= nxt_state != DDRDR_IDLE;
            if (nxt_state != state_ff)
            begin
                bit_cnt_ff <= 6'h0;
                clk_cnt_ff <= 5'h0;
            end
            if (state_ff == DDRDR_IDLE)
            begin
                wide_ff <= four_byte_address_mode;
                lat_ff  <= lat_clks(latency_code_field & LAT_CODE_MASK, enhanced_latency_table);
            end
            if (state_ff == DDRDR_INSTR && ev.rise)
            begin
                shift_ff <= {shift_ff[30:0], ev.lines[0]};
                if (nxt_state == state_ff)
                    bit_cnt_ff <= bit_cnt_ff + 6'h1;
                if (nxt_state == DDRDR_ADDR)
                    wide_ff <= four_byte_address_mode | ({shift_ff[6:0], ev.lines[0]} == OPC_DDR_DUAL_WIDE);
            end
            if ((state_ff == DDRDR_ADDR || state_ff == DDRDR_MODE) && dual_edge)
            begin
                shift_ff <= {shift_ff[29:0], ev.lines[1], ev.lines[0]};
                if (nxt_state == state_ff)
                    bit_cnt_ff <= bit_cnt_ff + 6'h2;
            end
            // latency: line values ignored, only clocks counted
            if (state_ff == DDRDR_LAT && ev.rise && nxt_state == state_ff)
                clk_cnt_ff <= clk_cnt_ff + 5'h1;
            // data phase: bit_cnt_ff counts edges, two low bits give the pair within the byte
            if (state_ff == DDRDR_DATA && edge_any && nxt_state == state_ff)
                bit_cnt_ff <= bit_cnt_ff + 6'h1;
        end
    end

    // address capture, mode decision and continuous-mode tracking
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_ff      <= 32'h0;
            cont_ff      <= 1'b0;
            cont_drop_ff <= 1'b0;
            sel_clks_ff  <= 5'h0;
        end
        else
        begin
            if (ev.sel_start)
                sel_clks_ff <= 5'h0;
            else if (ev.sel && ev.rise && sel_clks_ff != 5'h1f)
                sel_clks_ff <= sel_clks_ff + 5'h1;
            if (state_ff == DDRDR_ADDR && nxt_state != DDRDR_ADDR && !abort)
                addr_ff <= {addr_in[29:0], ev.lines[1], ev.lines[0]} & (wide_ff ? 32'hffff_ffff : 32'h00ff_ffff);
            if (state_ff == DDRDR_MODE && nxt_state == DDRDR_LAT)
            begin
                cont_drop_ff <= !mode_cmpl;
                if (mode_cmpl)
                    cont_ff <= 1'b1;
            end
            if (byte_step)
                addr_ff <= addr_nxt;
            if (ev.sel_end)
            begin
                if (cont_drop_ff || !enhanced_latency_table)
                    cont_ff <= 1'b0;
                if (state_ff == DDRDR_SKIP || sel_clks_ff <= SHORT_SEL_CLKS)
                    cont_ff <= 1'b0;
                cont_drop_ff <= 1'b0;
            end
        end
    end

    // byte buffer: one byte per two clocks, two bits per edge, msb first
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dbyte_ff <= 8'h0;
            out_ff   <= 2'h0;
            oe_ff    <= 1'b0;
        end
        else
        begin
            if (state_ff != DDRDR_DATA)
                dbyte_ff <= array_data;
            if (abort || state_ff == DDRDR_IDLE)
                oe_ff <= 1'b0;
            else if (state_ff == DDRDR_LAT && nxt_state == DDRDR_DATA)
            begin
                oe_ff  <= 1'b1;
                out_ff <= dbyte_ff[7:6];
            end
            else if (state_ff == DDRDR_LAT && pre_phase && edge_any)
            begin
                oe_ff  <= 1'b1;
                out_ff <= {2{learning_pattern[3'h7 - pre_idx]}};
            end
            else if (state_ff == DDRDR_DATA && edge_any)
            begin
                case (bit_cnt_ff[1:0])
                    2'h0:    out_ff <= dbyte_ff[5:4];
                    2'h1:    out_ff <= dbyte_ff[3:2];
                    2'h2:    out_ff <= dbyte_ff[1:0];
                    default: out_ff <= array_data[7:6];
                endcase
                if (byte_load)
                    dbyte_ff <= array_data;
            end
        end
    end

    assign serial_line_zero_out = out_ff[0];
    assign serial_line_one_out  = out_ff[1];
    assign serial_line_zero_oe  = oe_ff;
    assign serial_line_one_oe   = oe_ff;
    assign array_addr           = addr_ff;
    assign continuous_mode      = cont_ff;
    assign busy                 = busy_ff;

    a_wrap_to_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (byte_step && addr_ff >= ARRAY_TOP)
        |=> addr_ff == 32'h0) else $error("address did not wrap");
    a_addr_step: assert property (@(posedge clk) disable iff (!arst_n)
        (byte_step && addr_ff < ARRAY_TOP)
        |=> addr_ff == $past(addr_ff) + 32'h1) else $error("address did not advance");
    a_pattern_lines: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == DDRDR_LAT && oe_ff) |-> out_ff[0] == out_ff[1]) else $error("pattern differs on lines");
    a_preamble_on: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == DDRDR_LAT && nxt_state == DDRDR_DATA && learning_pattern_en) |-> oe_ff)
        else $error("preamble not driven");
    a_short_select: assert property (@(posedge clk) disable iff (!arst_n)
        (ev.sel_end && sel_clks_ff <= SHORT_SEL_CLKS) |=> !cont_ff) else $error("short select kept mode");
    a_no_drive_idle: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == DDRDR_IDLE |=> !oe_ff) else $error("lines driven while idle");
    a_cont_entry: assert property (@(posedge clk) disable iff (!arst_n)
        (cont_ff && ev.sel_start && state_ff == DDRDR_IDLE) |=> state_ff == DDRDR_ADDR)
        else $error("continuous mode did not skip instruction");
    a_basic_no_mode: assert property (@(posedge clk) disable iff (!arst_n)
        !enhanced_latency_table && $stable(enhanced_latency_table) |-> state_ff != DDRDR_MODE)
        else $error("mode cycles with basic table");
    a_cont_release: assert property (@(posedge clk) disable iff (!arst_n)
        (ev.sel_end && state_ff == DDRDR_SKIP) |=> !cont_ff) else $error("continuous mode kept");
    a_mode_release: assert property (@(posedge clk) disable iff (!arst_n)
        (ev.sel_end && cont_drop_ff) |=> !cont_ff) else $error("mode release missed");
    a_data_drives: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == DDRDR_DATA && !abort) |=> oe_ff) else $error("data not driven");
endmodule
`default_nettype wire

/* File: common/ddrdr_pkg.sv */
// constants and types for the ddr dual-line read engine
package ddrdr_pkg;
    localparam logic [7:0]  OPC_DDR_DUAL      = 8'hbd;
    localparam logic [7:0]  OPC_DDR_DUAL_WIDE = 8'hbe;
    localparam int          ADDR_W            = 32;
    localparam logic [31:0] ARRAY_TOP_DEF     = 32'h00ff_ffff;
    localparam logic [7:0]  PATTERN_DEF       = 8'h34;
    localparam logic [4:0]  PREAMBLE_CLKS     = 5'h04;
    localparam logic [4:0]  MODE_CLKS         = 5'h02;
    localparam logic [4:0]  SHORT_SEL_CLKS    = 5'h08;
    localparam logic [4:0]  INSTR_BITS        = 5'h08;
    localparam logic [1:0]  LAT_CODE_MASK     = 2'h3;
    localparam int          SCK_MAX_MHZ       = 80;
    typedef enum logic [2:0] {
        DDRDR_IDLE  = 3'b000,
        DDRDR_INSTR = 3'b001,
        DDRDR_ADDR  = 3'b010,
        DDRDR_MODE  = 3'b011,
        DDRDR_LAT   = 3'b100,
        DDRDR_DATA  = 3'b101,
        DDRDR_SKIP  = 3'b110
    } ddrdr_state_e;
    // latency clocks for a latency code; enhanced table includes mode budget
    function automatic logic [4:0] lat_clks(input logic [1:0] code, input logic enh);
        logic [4:0] base;
        base = 5'h04 + {1'b0, code, 2'h0} / 5'h02;
        lat_clks = enh ? base + 5'h02 : base + 5'h01;
    endfunction
endpackage

/* File: common/ddrdr_edge_if.sv */
// edge events of the serial clock carried from sampler to engine
`timescale 1ns/1ps
`default_nettype none
interface ddrdr_edge_if;
    logic       rise;
    logic       fall;
    logic       sel;
    logic       sel_start;
    logic       sel_end;
    logic [1:0] lines;
    modport src (output rise, fall, sel, sel_start, sel_end, lines);
    modport dst (input rise, fall, sel, sel_start, sel_end, lines);
endinterface
`default_nettype wire

/* File: rtl/ddrdr_sync.sv */
// synchronises the pins and finds serial clock and select edges
`timescale 1ns/1ps
`default_nettype none
module ddrdr_sync
    import ddrdr_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   arst_n,
    // pins
    input  wire logic   sck,
    input  wire logic   sel_n,
    input  wire logic   line0_in,
    input  wire logic   line1_in,
    // events
    ddrdr_edge_if.src   ev
);
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic       sck_d_ff;
    // reset to the idle levels: clock low, not selected, so no false edge follows reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff  <= 4'h0;
            sync_ff  <= 4'h0;
            sck_d_ff <= 1'b0;
        end
        else
        begin
            meta_ff  <= {line1_in, line0_in, ~sel_n, sck};
            sync_ff  <= meta_ff;
            sck_d_ff <= sync_ff[0];
        end
    end
    logic sel_prev_ff;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sel_prev_ff <= 1'b0;
        else
            sel_prev_ff <= sync_ff[1];
    end
    assign ev.rise      = sync_ff[0] & ~sck_d_ff;
    assign ev.fall      = ~sync_ff[0] & sck_d_ff;
    assign ev.sel       = sync_ff[1];
    assign ev.sel_start = sync_ff[1] & ~sel_prev_ff;
    assign ev.sel_end   = ~sync_ff[1] & sel_prev_ff;
    assign ev.lines     = sync_ff[3:2];
endmodule
`default_nettype wire

/* File: verif/ddrdr_host.sv */
// host controller model driving select, serial clock and both lines
`timescale 1ns/1ps
`default_nettype none
module ddrdr_host
(
    // system clock
    input  wire logic       clk,
    // device side of the lines
    input  wire logic [1:0] dev_out,
    input  wire logic [1:0] dev_oe,
    // host pins and resolved line levels
    output logic            sck,
    output logic            sel_n,
    output logic [1:0]      lvl
);
    logic [1:0] hv;
    logic [1:0] hoe;
    logic [1:0] last_ff;
    logic [1:0] obs_v[$];
    logic [1:0] obs_oe[$];
    int         dstart;
    // a released line shows the inverse of its last level
    assign lvl[0] = hoe[0] ? hv[0] : (dev_oe[0] ? dev_out[0] : ~last_ff[0]);
    assign lvl[1] = hoe[1] ? hv[1] : (dev_oe[1] ? dev_out[1] : ~last_ff[1]);
    always_ff @(posedge clk)
    begin
        last_ff <= lvl;
    end
    initial
    begin
        sck   = 1'b0;
        sel_n = 1'b1;
        hv    = 2'h0;
        hoe   = 2'h3;
    end
    // half period of 40 ns: sample, drive, then move the clock
    task automatic half(input logic [1:0] v, input logic [1:0] oe);
        #10;
        obs_v.push_back(lvl);
        obs_oe.push_back(dev_oe);
        #10;
        hv  = v;
        hoe = oe;
        #20;
        sck = ~sck;
    endtask
    task automatic frame(input logic ins, input logic [7:0] opc, input int nab, input logic [31:0] a,
                         input logic men, input logic [7:0] m, input int lat, input logic pre, input int nby);
        int i;
        obs_v.delete();
        obs_oe.delete();
        sel_n = 1'b0;
        if (ins)
            for (i = 0; i < 16; i++)
                half({1'b0, opc[7 - i / 2]}, 2'h3);
        for (i = 0; i < nab * 4; i++)
            half({a[nab * 8 - 1 - 2 * i], a[nab * 8 - 2 - 2 * i]}, 2'h3);
        if (men)
            for (i = 0; i < 4; i++)
                half({m[7 - 2 * i], m[6 - 2 * i]}, 2'h3);
        for (i = 0; i < lat * 2; i++)
            half(pre ? 2'h0 : {i[0], ~i[0]}, pre ? 2'h0 : 2'h3);
        dstart = obs_v.size();
        for (i = 0; i < nby * 4; i++)
            half(2'h0, 2'h0);
        #10;
        obs_v.push_back(lvl);
        obs_oe.push_back(dev_oe);
    endtask
    task automatic close();
        #30;
        sel_n = 1'b1;
        hoe   = 2'h3;
        hv    = 2'h0;
        #200;
    endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the ddr dual-line read engine
`timescale 1ns/1ps
`default_nettype none
module tb
    import ddrdr_pkg::*;
;
    typedef struct {
        logic        ins;
        logic [7:0]  opc;
        logic        fb;
        logic        enh;
        logic [1:0]  lcode;
        logic        pre;
        logic        hold;
        logic [31:0] a;
        logic [7:0]  m;
        logic        ok;
        logic        cm;
    } ddrdr_row_s;
    logic        clk    = 1'b0;
    logic        arst_n = 1'b0;
    logic        hold_n = 1'b1;
    logic        fb     = 1'b0;
    logic        enh    = 1'b0;
    logic [1:0]  lcode  = 2'h0;
    logic        pre    = 1'b0;
    logic [7:0]  pat    = 8'h34;
    logic        sck;
    logic        sel_n;
    logic [1:0]  lvl;
    logic [1:0]  dout;
    logic [1:0]  doe;
    logic [31:0] array_addr;
    logic [7:0]  array_data;
    logic        cmode;
    logic        busy;
    int          i;
    int          num_errors = 0;
    int          num_checks = 0;
    // ins opc fb enh lcode pre hold addr mode ok cm
    ddrdr_row_s  rows [0:5] = '{
        '{1'b1, 8'hbd, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 32'h0000_0123, 8'h00, 1'b1, 1'b0},
        '{1'b1, 8'hbd, 1'b1, 1'b0, 2'h1, 1'b1, 1'b0, 32'h00ff_fffe, 8'h00, 1'b1, 1'b0},
        '{1'b1, 8'hbd, 1'b1, 1'b1, 2'h2, 1'b1, 1'b1, 32'h0012_3456, 8'ha5, 1'b1, 1'b1},
        '{1'b0, 8'h00, 1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 32'h0000_8001, 8'h00, 1'b1, 1'b1},
        '{1'b1, 8'h0b, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 32'h0000_0000, 8'h00, 1'b0, 1'b0},
        '{1'b1, 8'hbe, 1'b0, 1'b1, 2'h0, 1'b0, 1'b1, 32'h00ab_cdef, 8'h5a, 1'b1, 1'b1}};
    always #5 clk = ~clk;
    assign array_data = array_addr[7:0] + array_addr[23:16] + 8'h11;
    ddrdr_top ddrdr_top_i (
        .clk(clk), .arst_n(arst_n), .sck(sck), .sel_n(sel_n), .hold_n(hold_n),
        .serial_line_zero_in(lvl[0]), .serial_line_one_in(lvl[1]),
        .serial_line_zero_out(dout[0]), .serial_line_one_out(dout[1]),
        .serial_line_zero_oe(doe[0]), .serial_line_one_oe(doe[1]),
        .four_byte_address_mode(fb), .enhanced_latency_table(enh), .latency_code_field(lcode),
        .learning_pattern_en(pre), .learning_pattern(pat), .array_addr(array_addr),
        .array_data(array_data), .continuous_mode(cmode), .busy(busy));
    ddrdr_host host_i (.clk(clk), .dev_out(dout), .dev_oe(doe), .sck(sck), .sel_n(sel_n), .lvl(lvl));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] exp_byte(input logic [31:0] a, input int b);
        logic [31:0] ea;
        ea = a + b;
        if (ea > ARRAY_TOP_DEF)
            ea = ea - ARRAY_TOP_DEF - 32'h1;
        exp_byte = ea[7:0] + ea[23:16] + 8'h11;
    endfunction
    task automatic run(input ddrdr_row_s r, input int nby, input logic [7:0] p);
        int         nab;
        int         lat;
        int         d;
        int         b;
        int         j;
        logic [7:0] e;
        nab    = (r.opc == OPC_DDR_DUAL_WIDE || r.fb) ? 4 : 3;
        lat    = 4 + 2 * r.lcode + (r.enh ? 2 : 1);
        fb     = r.fb;
        enh    = r.enh;
        lcode  = r.lcode;
        pre    = r.pre;
        pat    = p;
        hold_n = r.hold;
        @(negedge clk);
        host_i.frame(r.ins, r.opc, nab, r.a, r.enh, r.m, lat, r.pre, nby);
        d = host_i.dstart;
        for (b = 0; b < nby; b++)
        begin
            e = exp_byte(r.a, b);
            for (j = 0; j < 4; j++)
            begin
                check(host_i.obs_oe[d + 1 + 4 * b + j], r.ok ? 2'h3 : 2'h0);
                if (r.ok)
                    check(host_i.obs_v[d + 1 + 4 * b + j], e[7 - 2 * j -: 2]);
            end
        end
        if (r.pre)
            for (j = 0; j < 8; j++)
                check(host_i.obs_v[d - 7 + j], {2{p[7 - j]}});
        check(cmode, r.cm);
        host_i.close();
        check(busy, 1'b0);
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        check({doe, cmode, busy}, 4'h0);
        repeat (4) @(negedge clk);
        for (i = 0; i < 6; i++)
            run(rows[i], (i == 1) ? 4 : 2, (i == 2) ? 8'hc9 : 8'h34);
        // short select with no instruction while continuous
        host_i.frame(1'b0, 8'h00, 1, 32'h0000_00ff, 1'b0, 8'h00, 0, 1'b0, 0);
        host_i.close();
        check(cmode, 1'b0);
        // reset at the start of the data phase
        enh = 1'b1;
        fb  = 1'b0;
        pre = 1'b0;
        fork
            host_i.frame(1'b1, OPC_DDR_DUAL, 3, 32'h0000_0040, 1'b1, 8'ha5, 6, 1'b0, 2);
            begin
                repeat (180) @(negedge clk);
                arst_n = 1'b0;
            end
        join
        check({doe, cmode, busy}, 4'h0);
        check(array_addr, 32'h0);
        host_i.close();
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        check({doe, cmode, busy}, 4'h0);
        end_sim();
    end
    initial
    begin
        #200000;
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
